/* rtl/lmx_pkg.sv */
// lmx_pkg: constants, field layouts, state type and scan helpers of the led matrix register map.
// assumes a byte-wide register port fed by an external two-wire serial engine.
//
// Behaviour
// - page select picks brightness page 00, current scale page 01, function page 02.
// - brightness page holds one rw byte per dot at 01h..90h, reset zero.
// - each dot sinks for brightness/256 of its row slot, within the scan duty.
// - scale page holds one rw byte per dot at 01h..90h, reset zero.
// - dot peak current code is global scale/256 times dot scale/256.
// - global current scale at function offset 01h, rw, reset zero, scales all columns.
// - configuration 00h: scan D7:D4, logic level D3, detect D2:D1, shutdown D0.
// - shutdown bit zero keeps the device shut down; one runs normally. (the code leaves shutdown and scans while a detection runs)
// - detect field: 00 none, 01 or 11 open, 10 short.
// - open code runs detection once; rerun needs 00 written first.
// - short code runs detection once; rerun needs 00 written first.
// - scan codes 0..3 give duty 1/11..1/8 over all eight rows.
// - codes 4..9 scan seven down to two rows, higher rows held off.
// - code 1010 stops scanning, columns only sink; higher codes not allowed.
// - resistor register D7 selects 0 or 180 degree phase delay.
// - D6:D4 selects row pull-down: none, off-time only, or always.
// - D2:D0 selects column pull-up likewise; D3 unused.
// - function offsets 03h..1Ah are read-only detection results, reset zero.
// - function offset 2Fh is write-only and restores every register default.
// - register reset acts only when 0xAE is written.
// - page select takes one write after unlock gets 0xC5; unlock then clears.
package lmx_pkg;
	localparam logic [7:0] REG_ID       = 8'hfc;
	localparam logic [7:0] REG_PAGE     = 8'hfd;
	localparam logic [7:0] REG_UNLOCK   = 8'hfe;
	localparam logic [7:0] UNLOCK_KEY   = 8'hc5;
	localparam logic [7:0] PAGE_BRIGHT  = 8'h00;
	localparam logic [7:0] PAGE_SCALE   = 8'h01;
	localparam logic [7:0] PAGE_FUNC    = 8'h02;
	localparam logic [7:0] DOT_FIRST    = 8'h01;
	localparam logic [7:0] DOT_LAST     = 8'h90;
	localparam logic [7:0] FR_CONFIG    = 8'h00;
	localparam logic [7:0] FR_GCS       = 8'h01;
	localparam logic [7:0] FR_PULL      = 8'h02;
	localparam logic [7:0] FR_RES_FIRST = 8'h03;
	localparam logic [7:0] FR_RES_LAST  = 8'h1a;
	localparam logic [7:0] FR_THERMAL   = 8'h24;
	localparam logic [7:0] FR_SPREAD    = 8'h25;
	localparam logic [7:0] FR_RESET     = 8'h2f;
	localparam logic [7:0] RESET_KEY    = 8'hae;
	localparam logic [7:0] ZERO_BYTE    = 8'h00;
	localparam logic [7:0] PULL_RESET   = 8'h55;
	localparam logic [7:0] PULL_MASK    = 8'hf7;
	localparam logic [7:0] THERMAL_MASK = 8'h0f;
	localparam logic [7:0] SPREAD_MASK  = 8'hdf;
	localparam int CFG_SWS_LO = 4;
	localparam int CFG_LGC    = 3;
	localparam int CFG_OSD_LO = 1;
	localparam int CFG_SSD    = 0;
	localparam int PULL_PHC   = 7;
	localparam int PULL_ROW_LO = 4;
	localparam int PULL_COL_LO = 0;
	localparam logic [1:0] OSD_OFF   = 2'h0;
	localparam logic [1:0] OSD_SHORT = 2'h2;
	localparam logic [3:0] SWS_ALL8_LAST = 4'h3;
	localparam logic [3:0] SWS_SCAN_LAST = 4'h9;
	localparam logic [3:0] SWS_NOSCAN    = 4'ha;
	localparam logic [3:0] SWS_DETECT    = 4'h3;
	localparam logic [3:0] SLOT_BASE     = 4'hb;
	localparam logic [3:0] ROWS_ALL      = 4'h8;
	localparam logic [3:0] ONE_SLOT      = 4'h1;
	localparam logic [7:0] PWM_LAST      = 8'hff;
	localparam logic [7:0] PHASE_HALF    = 8'h80;
	localparam int NUM_ROWS = 8;
	localparam int NUM_COLS = 18;
	localparam int NUM_DOTS = 144;
	localparam int RES_COLS = 6;
	localparam int RES_PER_ROW = 3;
	localparam int NUM_RES  = 24;

	typedef enum logic [1:0] {DET_IDLE, DET_ARM, DET_RUN} lmx_det_type;

	// slots per scan period: rows plus idle slots that set the duty
	function automatic logic [3:0] scanSlots(input logic [3:0] code);
		return (code <= SWS_SCAN_LAST) ? 4'(SLOT_BASE - code) : ONE_SLOT;
	endfunction

	function automatic logic [3:0] scanRows(input logic [3:0] code);
		if (code <= SWS_ALL8_LAST) begin
			return ROWS_ALL;
		end
		return (code <= SWS_SCAN_LAST) ? 4'(SLOT_BASE - code) : 4'h0;
	endfunction
endpackage

/* rtl/lmx_scan_if.sv */
// lmx_scan_if: link between the register map and the scan sequencer.
// assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface lmx_scan_if;
	logic       ce;
	logic       run;
	logic [3:0] code;
	logic [7:0] pwmStep;
	logic [3:0] slot;
	logic       rowActive;
	logic       slotEnd;
	modport seq (input ce, run, code, output pwmStep, slot, rowActive, slotEnd);
	modport ctl (output ce, run, code, input pwmStep, slot, rowActive, slotEnd);
endinterface
`default_nettype wire

/* rtl/lmx_scan.sv */
// lmx_scan: pwm step and row slot counters of the matrix scan.
// assumes run drops whenever the scan must restart from slot zero.
`timescale 1ns/10ps
`default_nettype none
module lmx_scan import lmx_pkg::*; (
	input wire logic ref_clk,
	input wire logic resetn,
	lmx_scan_if.seq  sif
);
	logic [7:0] pwmStep_r;
	logic [3:0] slot_r;
	logic [3:0] slotNxt;

	assign slotNxt = slot_r + 4'h1;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pwmStep_r <= ZERO_BYTE;
			slot_r    <= 4'h0;
		end else if (sif.ce) begin
			if (!sif.run) begin
				pwmStep_r <= ZERO_BYTE;
				slot_r    <= 4'h0;
			end else begin
				pwmStep_r <= pwmStep_r + 8'h01;
				if (pwmStep_r == PWM_LAST) begin
					slot_r <= (slotNxt >= scanSlots(sif.code)) ? 4'h0 : slotNxt;
				end
			end
		end
	end

	assign sif.pwmStep   = pwmStep_r;
	assign sif.slot      = slot_r;
	assign sif.slotEnd   = sif.run && (pwmStep_r == PWM_LAST);
	// idle slots and rows above the scanned count stay off
	assign sif.rowActive = sif.run && (sif.code <= SWS_SCAN_LAST)
		&& (slot_r < scanRows(sif.code));
endmodule
`default_nettype wire

/* rtl/lmx_regmap.sv */
// lmx_regmap: paged register map, pwm column drive and open/short detection control.
// assumes a byte register port from the serial engine, one access per cycle at most.
`timescale 1ns/10ps
`default_nettype none
module lmx_regmap import lmx_pkg::*; #(
	parameter logic [7:0] ID_VALUE = 8'h5a // arbitrary identification value
) (
	input  wire logic                       ref_clk,
	input  wire logic                       resetn,
	input  wire logic                       ce,
	input  wire logic                       regWrite,
	input  wire logic                       regRead,
	input  wire logic [7:0]                 regAddr,
	input  wire logic [7:0]                 regWrData,
	output var  logic [7:0]                 regRdData,
	output var  logic                       regRdValid,
	input  wire logic [NUM_COLS-1:0]        faultSense,
	output var  logic [NUM_ROWS-1:0]        rowSwitch,
	output var  logic [NUM_COLS-1:0]        colSink,
	output var  logic [NUM_COLS*8-1:0]      colLevel,
	output var  logic                       detectOpen,
	output var  logic                       detectShort,
	output var  logic                       shutdownActive,
	output var  logic                       logicLevelHigh,
	output var  logic                       phaseDelay180,
	output var  logic [2:0]                 rowPulldownSel,
	output var  logic [2:0]                 columnPullupSel,
	output var  logic [3:0]                 thermalSetting,
	output var  logic [7:0]                 spreadSetting
);
	// ******************************************************
	// storage
	// ******************************************************
	logic [7:0]        pageSel_r;
	logic [7:0]        unlock_r;
	logic [7:0]        config_r;
	logic [7:0]        globalScale_r;
	logic [7:0]        pull_r;
	logic [7:0]        thermal_r;
	logic [7:0]        spread_r;
	logic [7:0]        bright_r [NUM_DOTS];
	logic [7:0]        dotScale_r [NUM_DOTS];
	logic [RES_COLS-1:0] detRes_r [NUM_RES];
	lmx_det_type       detState_r;
	logic              detShortMode_r;
	logic              osdArmed_r;

	lmx_scan_if sif ();

	lmx_scan u_scan (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.sif     (sif)
	);

	// ******************************************************
	// helpers
	// ******************************************************
	function automatic logic isDot(input logic [7:0] a);
		return (a >= DOT_FIRST) && (a <= DOT_LAST);
	endfunction

	// dot index of a row and column; rows are NUM_COLS dots apart
	function automatic logic [7:0] dotAt(input logic [3:0] row, input int col);
		return 8'(int'(row) * NUM_COLS + col);
	endfunction

	// late columns run half a pwm period behind when the phase delay is on
	function automatic logic pwmOn(input logic [7:0] step, input logic [7:0] level,
		input logic late);
		return (late ? (step ^ PHASE_HALF) : step) < level;
	endfunction

	// ******************************************************
	// access decode
	// ******************************************************
	logic       wrEn;
	logic       onBright;
	logic       onScale;
	logic       onFunc;
	logic       dotAddr;
	logic [7:0] dotIdx;
	logic       wrReset;
	logic       clearAll;
	logic       wrConfig;
	logic [1:0] newOsd;
	logic       detStart;

	assign wrEn     = ce && regWrite;
	assign onBright = (pageSel_r == PAGE_BRIGHT);
	assign onScale  = (pageSel_r == PAGE_SCALE);
	assign onFunc   = (pageSel_r == PAGE_FUNC);
	assign dotAddr  = isDot(regAddr);
	assign dotIdx   = 8'(regAddr - DOT_FIRST);
	assign wrReset  = wrEn && onFunc && (regAddr == FR_RESET)
		&& (regWrData == RESET_KEY);
	assign clearAll = !resetn || wrReset;
	assign wrConfig = wrEn && onFunc && (regAddr == FR_CONFIG);
	assign newOsd   = regWrData[CFG_OSD_LO+:2];
	// a detection starts only from a field that was last written 00
	assign detStart = wrConfig && osdArmed_r && (newOsd != OSD_OFF)
		&& (detState_r == DET_IDLE);

	// ******************************************************
	// page select and unlock
	// ******************************************************
	always_ff @(posedge ref_clk) begin
		if (clearAll) begin
			pageSel_r <= PAGE_BRIGHT;
			unlock_r  <= ZERO_BYTE;
		end else if (wrEn) begin
			if (regAddr == REG_UNLOCK) begin
				unlock_r <= regWrData;
			end else if (regAddr == REG_PAGE && unlock_r == UNLOCK_KEY) begin
				pageSel_r <= regWrData;
				unlock_r  <= ZERO_BYTE;
			end
		end
	end

	// ******************************************************
	// function registers
	// ******************************************************
	always_ff @(posedge ref_clk) begin
		if (clearAll) begin
			config_r      <= ZERO_BYTE;
			globalScale_r <= ZERO_BYTE;
			pull_r        <= PULL_RESET;
			thermal_r     <= ZERO_BYTE;
			spread_r      <= ZERO_BYTE;
		end else if (wrEn && onFunc) begin
			unique case (regAddr)
				FR_CONFIG:  config_r      <= regWrData;
				FR_GCS:     globalScale_r <= regWrData;
				FR_PULL:    pull_r        <= regWrData & PULL_MASK;
				FR_THERMAL: thermal_r     <= regWrData & THERMAL_MASK;
				FR_SPREAD:  spread_r      <= regWrData & SPREAD_MASK;
				default:    pull_r        <= pull_r;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (clearAll) begin
			osdArmed_r <= 1'b1;
		end else if (wrConfig) begin
			osdArmed_r <= (newOsd == OSD_OFF);
		end
	end

	// ******************************************************
	// dot arrays
	// ******************************************************
	always_ff @(posedge ref_clk) begin
		if (clearAll) begin
			for (int i = 0; i < NUM_DOTS; i++) begin
				bright_r[i]   <= ZERO_BYTE;
				dotScale_r[i] <= ZERO_BYTE;
			end
		end else if (wrEn && dotAddr) begin
			if (onBright) begin
				bright_r[dotIdx] <= regWrData;
			end
			if (onScale) begin
				dotScale_r[dotIdx] <= regWrData;
			end
		end
	end

	// ******************************************************
	// open/short detection
	// ******************************************************
	always_ff @(posedge ref_clk) begin
		if (clearAll) begin
			detState_r     <= DET_IDLE;
			detShortMode_r <= 1'b0;
		end else if (ce) begin
			unique case (detState_r)
				DET_IDLE: begin
					if (detStart) begin
						detState_r     <= DET_ARM;
						detShortMode_r <= (newOsd == OSD_SHORT);
					end
				end
				DET_ARM: begin
					detState_r <= DET_RUN;
				end
				DET_RUN: begin
					if (sif.slotEnd && sif.slot == 4'(NUM_ROWS - 1)) begin
						detState_r <= DET_IDLE;
					end
				end
			endcase
		end
	end

	// each row is sampled at the end of its slot, six columns per result byte
	always_ff @(posedge ref_clk) begin
		if (clearAll) begin
			for (int i = 0; i < NUM_RES; i++) begin
				detRes_r[i] <= '0;
			end
		end else if (ce && detState_r == DET_RUN && sif.slotEnd) begin
			for (int k = 0; k < RES_PER_ROW; k++) begin
				detRes_r[5'(sif.slot * RES_PER_ROW + k)] <= faultSense[k*RES_COLS+:RES_COLS];
			end
		end
	end

	// ******************************************************
	// scan control
	// ******************************************************
	logic       detecting;
	logic       ssdOn;
	logic [3:0] swsCode;

	assign detecting = (detState_r != DET_IDLE);
	assign ssdOn     = config_r[CFG_SSD];
	assign swsCode   = config_r[CFG_SWS_LO+:4];
	assign sif.ce    = ce;
	// detection always walks all eight rows; arm restarts the counters
	assign sif.run   = (detState_r == DET_RUN)
		|| (!detecting && ssdOn && swsCode <= SWS_NOSCAN);
	assign sif.code  = detecting ? SWS_DETECT : swsCode;

	// ******************************************************
	// column and row drive
	// ******************************************************
	function automatic logic [7:0] peakCode(input logic [7:0] gcs, input logic [7:0] sl);
		logic [15:0] prod;
		prod = 16'(gcs) * 16'(sl);
		return prod[15:8];
	endfunction

	logic       noScan;
	logic [3:0] driveRow;

	assign noScan   = !detecting && ssdOn && (swsCode == SWS_NOSCAN);
	assign driveRow = noScan ? 4'h0 : sif.slot;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			rowSwitch <= '0;
			colSink   <= '0;
		end else if (ce) begin
			rowSwitch <= sif.rowActive ? NUM_ROWS'(1) << sif.slot : '0;
			for (int c = 0; c < NUM_COLS; c++) begin
				colSink[c] <= (sif.rowActive || (noScan && sif.run))
					&& pwmOn(sif.pwmStep, bright_r[dotAt(driveRow, c)],
					(c % 2 == 1) && phaseDelay180);
			end
		end
	end

	// peak current code follows the dot of the row being driven
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			colLevel <= '0;
		end else if (ce) begin
			for (int c = 0; c < NUM_COLS; c++) begin
				colLevel[c*8+:8] <= peakCode(globalScale_r,
					dotScale_r[dotAt(driveRow, c)]);
			end
		end
	end

	// ******************************************************
	// configuration outputs
	// ******************************************************
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			detectOpen  <= 1'b0;
			detectShort <= 1'b0;
		end else if (ce) begin
			detectOpen  <= (detState_r == DET_RUN) && !detShortMode_r;
			detectShort <= (detState_r == DET_RUN) && detShortMode_r;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			shutdownActive <= 1'b1;
		end else if (ce) begin
			shutdownActive <= !ssdOn && !detecting;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			phaseDelay180   <= 1'b0;
			rowPulldownSel  <= PULL_RESET[PULL_ROW_LO+:3];
			columnPullupSel <= PULL_RESET[PULL_COL_LO+:3];
		end else if (ce) begin
			phaseDelay180   <= pull_r[PULL_PHC];
			rowPulldownSel  <= pull_r[PULL_ROW_LO+:3];
			columnPullupSel <= pull_r[PULL_COL_LO+:3];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			logicLevelHigh <= 1'b0;
			thermalSetting <= '0;
			spreadSetting  <= ZERO_BYTE;
		end else if (ce) begin
			logicLevelHigh <= config_r[CFG_LGC];
			thermalSetting <= thermal_r[3:0];
			spreadSetting  <= spread_r;
		end
	end

	// ******************************************************
	// read path
	// ******************************************************
	function automatic logic [7:0] readMux(input logic [7:0] a);
		logic [7:0] v;
		v = ZERO_BYTE;
		if (a == REG_UNLOCK) begin
			v = unlock_r;
		end else if (a == REG_ID) begin
			v = ID_VALUE;
		end else if (isDot(a) && onBright) begin
			v = bright_r[8'(a - DOT_FIRST)];
		end else if (isDot(a) && onScale) begin
			v = dotScale_r[8'(a - DOT_FIRST)];
		end else if (onFunc) begin
			if (a == FR_CONFIG) begin
				v = config_r;
			end else if (a == FR_GCS) begin
				v = globalScale_r;
			end else if (a == FR_PULL) begin
				v = pull_r;
			end else if ((a >= FR_RES_FIRST) && (a <= FR_RES_LAST)) begin
				v = 8'(detRes_r[5'(a - FR_RES_FIRST)]);
			end else if (a == FR_THERMAL) begin
				v = thermal_r;
			end else if (a == FR_SPREAD) begin
				v = spread_r;
			end
		end
		return v;
	endfunction

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			regRdData  <= ZERO_BYTE;
			regRdValid <= 1'b0;
		end else if (ce) begin
			regRdValid <= regRead;
			if (regRead) begin
				regRdData <= readMux(regAddr);
			end
		end
	end
endmodule
`default_nettype wire

/* tb/lmx_regmap_sva.sv */
// lmx_regmap_sva: port checks of the led matrix register map.
// assumes a bind onto lmx_regmap, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module lmx_regmap_sva import lmx_pkg::*; (
	input wire logic                ref_clk,
	input wire logic                resetn,
	input wire logic                ce,
	input wire logic                regRead,
	input wire logic [7:0]          regRdData,
	input wire logic                regRdValid,
	input wire logic [NUM_ROWS-1:0] rowSwitch,
	input wire logic [NUM_COLS-1:0] colSink,
	input wire logic                detectOpen,
	input wire logic                detectShort,
	input wire logic                shutdownActive,
	input wire logic                phaseDelay180,
	input wire logic [2:0]          rowPulldownSel,
	input wire logic [2:0]          columnPullupSel
);
	logic [11:0] detCnt_r;

	// length of the current detection run
	always_ff @(posedge ref_clk) begin
		if (!resetn || !(detectOpen || detectShort)) begin
			detCnt_r <= 12'h000;
		end else begin
			detCnt_r <= detCnt_r + 12'h001;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	read_valid_a: assert property (ce && regRead |=> regRdValid)
		else $error("read without valid");
	valid_cause_a: assert property (regRdValid |-> $past(regRead) && $past(ce))
		else $error("valid without read");
	rd_hold_a: assert property (!regRdValid && $past(resetn) |-> $stable(regRdData))
		else $error("read data moved");
	reset_out_a: assert property ($rose(resetn) |-> shutdownActive && !phaseDelay180
		&& rowPulldownSel == PULL_RESET[PULL_ROW_LO+:3]
		&& columnPullupSel == PULL_RESET[PULL_COL_LO+:3]) else $error("bad reset outputs");
	row_onehot_a: assert property ($onehot0(rowSwitch))
		else $error("several rows on");
	det_excl_a: assert property (!(detectOpen && detectShort))
		else $error("open and short together");
	det_len_a: assert property ($fell(detectOpen || detectShort) && $past(resetn)
		|-> detCnt_r == 12'h800) else $error("detection run length");
	shut_dark_a: assert property ((shutdownActive && !detectOpen && !detectShort)[*3]
		|-> colSink == '0 && rowSwitch == '0) else $error("drive in shutdown");
endmodule

bind lmx_regmap lmx_regmap_sva chk_u (.ref_clk(ref_clk), .resetn(resetn), .ce(ce),
	.regRead(regRead), .regRdData(regRdData), .regRdValid(regRdValid),
	.rowSwitch(rowSwitch), .colSink(colSink), .detectOpen(detectOpen),
	.detectShort(detectShort), .shutdownActive(shutdownActive),
	.phaseDelay180(phaseDelay180), .rowPulldownSel(rowPulldownSel),
	.columnPullupSel(columnPullupSel));
`default_nettype wire

/* tb/lmx_host_model.sv */
// lmx_host_model: host side of the byte register port.
// assumes strobes change at the falling edge and are taken at the next rising edge.
`timescale 1ns/10ps
`default_nettype none
module lmx_host_model import lmx_pkg::*; (
	input  wire logic       ref_clk,
	output var  logic       regWrite,
	output var  logic       regRead,
	output var  logic [7:0] regAddr,
	output var  logic [7:0] regWrData
);
	logic [7:0] expQ[$];

	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
	end

	// one-cycle strobe, then idle address and data are scrambled
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		regWrite = w;
		regRead = !w;
		regAddr = a;
		regWrData = d;
		@(negedge ref_clk);
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		access(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expQ.push_back(e);
		access(1'b0, a, ~e);
	endtask

	task automatic setPage(input logic [7:0] p);
		wr(REG_UNLOCK, UNLOCK_KEY);
		wr(REG_PAGE, p);
	endtask
endmodule
`default_nettype wire

/* tb/test_led_matrix_register_map.sv */
// test_led_matrix_register_map: self-checking bench of the led matrix register map.
// assumes lmx_host_model drives the register port and the checker is bound.
`timescale 1ns/10ps
`default_nettype none
module test_led_matrix_register_map import lmx_pkg::*;;
	logic ref_clk = 1'b0;
	logic resetn, ce, regWrite, regRead, regRdValid;
	logic detectOpen, detectShort, shutdownActive, phaseDelay180;
	logic [7:0] regAddr, regWrData, regRdData;
	logic [2:0] rowPulldownSel, columnPullupSel;
	logic logicLevelHigh;
	logic [3:0] thermalSetting;
	logic [7:0] spreadSetting;
	logic [NUM_ROWS-1:0] rowSwitch, seen;
	logic [NUM_COLS-1:0] colSink, faultSense, f;
	logic [NUM_COLS*8-1:0] colLevel;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;

	always #4 ref_clk = ~ref_clk;

	lmx_host_model host_u (.ref_clk(ref_clk), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWrData(regWrData));
	lmx_regmap dut_u (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.regRdValid(regRdValid), .faultSense(faultSense), .rowSwitch(rowSwitch),
		.colSink(colSink), .colLevel(colLevel), .detectOpen(detectOpen),
		.detectShort(detectShort), .shutdownActive(shutdownActive),
		.logicLevelHigh(logicLevelHigh),
		.phaseDelay180(phaseDelay180), .rowPulldownSel(rowPulldownSel),
		.columnPullupSel(columnPullupSel), .thermalSetting(thermalSetting),
		.spreadSetting(spreadSetting));

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tally_and_finish();
		if (n_errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		if (regRdValid === 1'b1) begin
			chk("regRdData", {8'h00, host_u.expQ.pop_front()}, {8'h00, regRdData});
		end
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	initial begin
		logic [7:0] b, s, g, m;
		int c, k, r, j, cnt, rows;
		resetn = 1'b0;
		ce = 1'b1;
		faultSense = '0;
		void'($urandom(32'h94e3d5af));
		repeat (16) @(negedge ref_clk);
		resetn = 1'b1;
		b = 8'($urandom());
		host_u.wr(DOT_FIRST, b);
		host_u.wr(REG_PAGE, PAGE_FUNC);
		host_u.rd(DOT_FIRST, b);
		host_u.rd(8'h91, ZERO_BYTE);
		host_u.setPage(PAGE_SCALE);
		host_u.rd(REG_UNLOCK, ZERO_BYTE);
		host_u.wr(DOT_LAST, ~b);
		host_u.rd(DOT_LAST, ~b);
		host_u.rd(DOT_FIRST, ZERO_BYTE);
		host_u.setPage(PAGE_FUNC);
		host_u.rd(FR_CONFIG, ZERO_BYTE);
		host_u.rd(FR_PULL, PULL_RESET);
		g = 8'($urandom());
		m = 8'($urandom());
		host_u.wr(FR_GCS, g);
		host_u.wr(FR_PULL, m);
		host_u.wr(FR_RES_LAST, 8'hff);
		// a write while the clock enable is low must be lost
		ce = 1'b0;
		host_u.wr(FR_GCS, ~g);
		ce = 1'b1;
		host_u.rd(FR_GCS, g);
		host_u.rd(FR_PULL, m & PULL_MASK);
		host_u.rd(FR_RES_LAST, ZERO_BYTE);
		chk("pull", {9'h0, m[7:4], m[2:0]},
			{9'h0, phaseDelay180, rowPulldownSel, columnPullupSel});
		host_u.wr(FR_THERMAL, 8'hff);
		host_u.wr(FR_SPREAD, 8'hff);
		host_u.wr(FR_CONFIG, 8'h08);
		host_u.rd(FR_CONFIG, 8'h08);
		chk("settings", {3'h0, 1'b1, THERMAL_MASK[3:0], SPREAD_MASK},
			{3'h0, logicLevelHigh, thermalSetting, spreadSetting});
		host_u.wr(FR_RESET, 8'had);
		host_u.rd(FR_GCS, g);
		host_u.wr(FR_RESET, RESET_KEY);
		host_u.rd(DOT_FIRST, ZERO_BYTE);
		host_u.setPage(PAGE_FUNC);
		host_u.rd(FR_PULL, PULL_RESET);
		host_u.rd(FR_SPREAD, ZERO_BYTE);
		chk("settingsReset", 16'h0,
			{3'h0, logicLevelHigh, thermalSetting, spreadSetting});
		host_u.wr(FR_GCS, 8'h01);
		for (k = 0; k < 3; k++) begin
			f = NUM_COLS'($urandom());
			faultSense = f;
			host_u.wr(FR_CONFIG, ZERO_BYTE);
			host_u.wr(FR_CONFIG, 8'(2 * k + 2));
			repeat (4) @(negedge ref_clk);
			chk("detectOpen", 16'(k != 1), 16'(detectOpen));
			chk("detectShort", 16'(k == 1), 16'(detectShort));
			cnt = 0;
			while ((detectOpen | detectShort) === 1'b1 && cnt < 2200) begin
				@(negedge ref_clk);
				cnt++;
			end
			chk("detectEnded", 16'h1, 16'(cnt < 2200));
			for (r = 0; r < 8; r++) begin
				for (j = 0; j < 3; j++) begin
					host_u.rd(8'(3 + 3 * r + j), {2'h0, f[6 * j +: 6]});
				end
			end
		end
		host_u.wr(FR_CONFIG, 8'h06);
		faultSense = ~f;
		repeat (6) @(negedge ref_clk);
		chk("detectOpen", 16'h0, 16'(detectOpen));
		host_u.rd(FR_RES_FIRST, {2'h0, f[5:0]});
		b = 8'($urandom());
		s = 8'($urandom());
		g = 8'($urandom());
		host_u.wr(FR_GCS, g);
		host_u.wr(FR_CONFIG, 8'h31);
		for (k = 0; k < 2; k++) begin
			host_u.setPage(8'(k));
			for (r = 1; r <= NUM_DOTS; r++) begin
				host_u.wr(8'(r), k == 0 ? b : s);
			end
		end
		repeat (300) @(negedge ref_clk);
		chk("shutdownActive", 16'h0, 16'(shutdownActive));
		cnt = 0;
		repeat (2048) begin
			@(negedge ref_clk);
			cnt += int'(colSink[NUM_COLS-1]);
		end
		chk("colSinkOn", 16'(8 * b), 16'(cnt));
		chk("colLevel", 16'((16'(g) * 16'(s)) >> 8), 16'(colLevel[7:0]));
		host_u.setPage(PAGE_FUNC);
		// with the half period delay two neighbouring columns overlap only above 128
		host_u.wr(FR_PULL, PULL_RESET | 8'(1 << PULL_PHC));
		repeat (4) @(negedge ref_clk);
		cnt = 0;
		repeat (2048) begin
			@(negedge ref_clk);
			cnt += int'(colSink[NUM_COLS-1] & colSink[NUM_COLS-2]);
		end
		chk("phaseOverlap", 16'(b > 8'h80 ? 16 * (int'(b) - 128) : 0), 16'(cnt));
		for (c = 0; c <= 10; c++) begin
			host_u.wr(FR_CONFIG, {4'(c), 4'h1});
			repeat (300) @(negedge ref_clk);
			seen = '0;
			repeat (2816) begin
				@(negedge ref_clk);
				seen |= rowSwitch;
			end
			rows = c <= 3 ? 8 : (c <= 9 ? 11 - c : 0);
			chk("rowsScanned", 16'((1 << rows) - 1), 16'(seen));
		end
		resetn = 1'b0;
		repeat (2) @(negedge ref_clk);
		resetn = 1'b1;
		host_u.rd(DOT_FIRST, ZERO_BYTE);
		repeat (4) @(negedge ref_clk);
		tally_and_finish();
	end
endmodule
`default_nettype wire
